// *** src/usif_regs.svh ***
// register map, field positions and timing constants of the status interrupt block
// Functional notes
// R1 - OR of all enabled flags forms the single interrupt request.
// R2 - a hardware-set flag stays set until firmware writes zero to it.
// R3 - firmware writing one to a writable flag bit sets that flag.
// R4 - while suspended the engine is unclocked; only bus activity can flag (the bit 1 error summary still follows enabled errors while suspended).
// R5 - bit 7 of the flag register is unimplemented and reads zero.
// R6 - start-of-frame token received sets bit 6.
// R7 - stall handshake sent sets bit 5.
// R8 - bus idle continuously for 3 ms or more sets bit 4.
// R9 - finished pending transaction sets bit 3; transfer status then readable.
// R10 - clearing bit 3 advances the transfer status FIFO (IN, OUT, SETUP only).
// R11 - activity on D+ or D- sets bit 2, also while suspended.
// R12 - bit 1 error summary is read-only, set only by enabled errors.
// R13 - valid bus reset sets bit 0 and loads function address with 00h.
// R14 - clears of the activity flag are ignored while suspended or resynchronising.
// R15 - engine on the 96 MHz PLL stays idle until the PLL locks.
// R16 - activity flags once per resume; rearmed only by a new idle flag.
// R17 - firmware clears suspend first, then clears activity until it reads zero.
// R18 - each flag has an enable bit gating it onto the interrupt request.
// R19 - enables gate only propagation; flags still set when disabled.
// R20 - error summary is OR of error flags gated by their enables.
// R21 - a hardware set and a firmware clear together: the set wins.
`ifndef USIF_REGS_SVH
`define USIF_REGS_SVH
`define USIF_OFS_FLAGS 8'h00
`define USIF_OFS_ENABLE 8'h04
`define USIF_OFS_CTRL 8'h08
`define USIF_OFS_FADDR 8'h0C
`define USIF_OFS_STATE 8'h10
`define USIF_BIT_RST 0
`define USIF_BIT_ERR 1
`define USIF_BIT_ACT 2
`define USIF_BIT_TRN 3
`define USIF_BIT_IDLE 4
`define USIF_BIT_STALL 5
`define USIF_BIT_SOF 6
`define USIF_BIT_UNUSED 7
`define USIF_BIT_SUSPEND 1
`define USIF_FLAGS_RESET 8'h00
`define USIF_ENABLE_RESET 8'h00
`define USIF_FADDR_RESET 7'h00
`define USIF_IDLE_US 3000
`define USIF_CLK_MHZ 100
`define USIF_RESYNC_CYCLES 4'h4
`endif

// *** src/usif_pkg.sv ***
// types shared by the status interrupt block
package usif_pkg;
   typedef enum logic [1:0] {
      ENG_RUN = 2'b00,
      ENG_SUSP = 2'b01,
      ENG_LOCK = 2'b10,
      ENG_RESYNC = 2'b11
   } usif_eng_t;
   typedef enum logic [1:0] {
      ACT_ARMED = 2'b00,
      ACT_SPENT = 2'b01
   } usif_act_t;
endpackage

// *** src/usif_flag_bit.sv ***
// one sticky status flag with firmware write and set priority
`timescale 1ns/10ps
`default_nettype none
module usif_flag_bit
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // set and write
   input wire logic hw_set,
   input wire logic sw_wr,
   input wire logic sw_val,
   input wire logic clr_block,
   // state
   output logic flag
);
   logic next_flag;

   always_comb
   begin
      next_flag = flag;
      if (sw_wr)
         next_flag = sw_val | (clr_block & flag); // [R2] [R3] [R14]
      if (hw_set)
         next_flag = 1'b1; // [R21]
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         flag <= 1'b0;
      else
         flag <= next_flag;
   end
endmodule
`default_nettype wire

// *** src/usif_idle_timer.sv ***
// continuous bus idle timer, one pulse per idle period
`timescale 1ns/10ps
`default_nettype none
module usif_idle_timer
#(
   parameter int unsigned CYCLES = 300000
)
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // line state
   input wire logic en,
   input wire logic idle,
   // event
   output logic pulse
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);
   localparam logic [W-1:0] FULL = W'(CYCLES);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic next_pulse;

   always_comb
   begin
      next_cnt = cnt;
      next_pulse = 1'b0;
      if (!idle || !en)
         next_cnt = '0;
      else if (cnt != FULL)
         next_cnt = cnt + W'(1);
      if (idle && en && cnt == LAST)
         next_pulse = 1'b1; // [R8]
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt <= '0;
         pulse <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         pulse <= next_pulse;
      end
   end
endmodule
`default_nettype wire

// *** src/usif_top.sv ***
// status interrupt flags, enables and suspend handling with an AHB-Lite slave
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "usif_regs.svh"
module usif_top
   import usif_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = `USIF_IDLE_US * `USIF_CLK_MHZ
)
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // serial engine events
   input wire logic SOF_RX,
   input wire logic STALL_TX,
   input wire logic TRN_DONE,
   input wire logic BUS_RESET,
   input wire logic BUS_ACTIVITY,
   input wire logic LINE_IDLE,
   input wire logic PLL_LOCKED,
   // second-level errors
   input wire logic [7:0] ERR_FLAGS,
   input wire logic [7:0] ERR_ENABLES,
   // outputs to the engine and the core
   output logic USB_IRQ,
   output logic ENGINE_CLK_EN,
   output logic SUSPEND,
   output logic [6:0] FUNC_ADDR,
   output logic STAT_FIFO_ADVANCE
);
   // bus state
   logic pend;
   logic wr;
   logic hit;
   logic [7:0] ofs;
   logic next_pend;
   logic next_wr;
   logic next_hit;
   logic [7:0] next_ofs;
   logic [31:0] next_rdata;
   logic next_ready;
   logic wr_now;
   logic wr_flags;

   // register state
   logic [7:0] enable;
   logic [7:0] next_enable;
   logic next_suspend;
   logic [6:0] next_faddr;
   logic err_sum;
   logic next_err_sum;
   logic next_irq;
   logic next_adv;

   // suspend and activity state
   usif_eng_t eng;
   usif_eng_t next_eng;
   usif_act_t act;
   usif_act_t next_act;
   logic [3:0] rsync;
   logic [3:0] next_rsync;
   logic next_clk_en;

   // flags
   logic [7:0] flags;
   logic [7:0] hw_set;
   logic run;
   logic idle_pulse;
   logic act_clr_block;

   assign run = (eng == ENG_RUN);
   assign act_clr_block = (eng != ENG_RUN); // [R14]
   assign wr_now = pend && !HREADYOUT && wr && hit;
   assign wr_flags = wr_now && ofs == `USIF_OFS_FLAGS;

   always_comb
   begin
      hw_set = 8'h00;
      hw_set[`USIF_BIT_SOF] = SOF_RX && run; // [R6] [R4]
      hw_set[`USIF_BIT_STALL] = STALL_TX && run; // [R7] [R4]
      hw_set[`USIF_BIT_IDLE] = idle_pulse && run; // [R8]
      hw_set[`USIF_BIT_TRN] = TRN_DONE && run; // [R9]
      hw_set[`USIF_BIT_ACT] = BUS_ACTIVITY && act == ACT_ARMED; // [R11] [R16]
      hw_set[`USIF_BIT_RST] = BUS_RESET && run; // [R13]
   end

   usif_idle_timer #(
      .CYCLES(IDLE_CYCLES)
   ) u_idle (
      .clk(SYS_CLK),
      .arst_n(ARST_N),
      .en(run),
      .idle(LINE_IDLE),
      .pulse(idle_pulse)
   );

   genvar i;
   generate
      for (i = 0; i < 7; i++)
      begin : g_flag
         if (i == `USIF_BIT_ERR)
         begin : g_err
            assign flags[i] = err_sum; // [R12]
         end
         else
         begin : g_bit
            usif_flag_bit u_bit (
               .clk(SYS_CLK),
               .arst_n(ARST_N),
               .hw_set(hw_set[i]),
               .sw_wr(wr_flags),
               .sw_val(HWDATA[i]),
               .clr_block(i == `USIF_BIT_ACT && act_clr_block),
               .flag(flags[i])
            );
         end
      end
   endgenerate
   assign flags[`USIF_BIT_UNUSED] = 1'b0; // [R5]

   // bus slave: one wait state, write applied and read sampled in it
   always_comb
   begin
      next_pend = pend;
      next_wr = wr;
      next_hit = hit;
      next_ofs = ofs;
      next_ready = HREADYOUT;
      next_rdata = HRDATA;
      if (pend && !HREADYOUT)
      begin
         next_pend = 1'b0;
         next_ready = 1'b1;
         next_rdata = 32'h0000_0000;
         if (hit && !wr)
         begin
            unique case (ofs)
               `USIF_OFS_FLAGS: next_rdata[7:0] = flags;
               `USIF_OFS_ENABLE: next_rdata[7:0] = enable;
               `USIF_OFS_CTRL: next_rdata[`USIF_BIT_SUSPEND] = SUSPEND;
               `USIF_OFS_FADDR: next_rdata[6:0] = FUNC_ADDR;
               `USIF_OFS_STATE: next_rdata[7:0] = {eng, act, rsync};
               default: next_rdata = 32'h0000_0000;
            endcase
         end
      end
      else if (HSEL && HTRANS[1] && HREADY)
      begin
         next_pend = 1'b1;
         next_ready = 1'b0;
         next_wr = HWRITE;
         next_ofs = HADDR[7:0];
         next_hit = HADDR[31:8] == 24'h00_0000 && HADDR[1:0] == 2'h0
            && HSIZE == 3'h2;
      end
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         pend <= 1'b0;
         wr <= 1'b0;
         hit <= 1'b0;
         ofs <= 8'h00;
         HREADYOUT <= 1'b1;
         HRDATA <= 32'h0000_0000;
         HRESP <= 1'b0;
      end
      else
      begin
         pend <= next_pend;
         wr <= next_wr;
         hit <= next_hit;
         ofs <= next_ofs;
         HREADYOUT <= next_ready;
         HRDATA <= next_rdata;
         HRESP <= 1'b0;
      end
   end

   // control registers, error summary, request and fifo advance
   always_comb
   begin
      next_enable = enable;
      next_suspend = SUSPEND;
      next_faddr = FUNC_ADDR;
      if (wr_now && ofs == `USIF_OFS_ENABLE)
         next_enable = {1'b0, HWDATA[6:0]};
      if (wr_now && ofs == `USIF_OFS_CTRL)
         next_suspend = HWDATA[`USIF_BIT_SUSPEND];
      if (wr_now && ofs == `USIF_OFS_FADDR)
         next_faddr = HWDATA[6:0];
      if (hw_set[`USIF_BIT_RST])
         next_faddr = `USIF_FADDR_RESET; // [R13]
      next_err_sum = |(ERR_FLAGS & ERR_ENABLES); // [R20]
      next_irq = |(flags & enable); // [R1] [R18] [R19]
      // only a firmware clear of a set done flag, with no hardware set that cycle, advances the fifo
      next_adv = wr_flags && flags[`USIF_BIT_TRN] && !HWDATA[`USIF_BIT_TRN]
         && !hw_set[`USIF_BIT_TRN]; // [R10]
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         enable <= `USIF_ENABLE_RESET;
         SUSPEND <= 1'b0;
         FUNC_ADDR <= `USIF_FADDR_RESET;
         err_sum <= 1'b0;
         USB_IRQ <= 1'b0;
         STAT_FIFO_ADVANCE <= 1'b0;
      end
      else
      begin
         enable <= next_enable;
         SUSPEND <= next_suspend;
         FUNC_ADDR <= next_faddr;
         err_sum <= next_err_sum;
         USB_IRQ <= next_irq;
         STAT_FIFO_ADVANCE <= next_adv;
      end
   end

   // suspend, pll lock and resync sequencing; activity arming
   always_comb
   begin
      next_eng = eng;
      next_rsync = rsync;
      next_act = act;
      unique case (eng)
         ENG_RUN:
            if (SUSPEND)
               next_eng = ENG_SUSP; // [R4]
         ENG_SUSP:
            if (!SUSPEND)
               next_eng = ENG_LOCK;
         ENG_LOCK:
            if (SUSPEND)
               next_eng = ENG_SUSP;
            else if (PLL_LOCKED)
            begin
               next_eng = ENG_RESYNC; // [R15]
               next_rsync = `USIF_RESYNC_CYCLES;
            end
         ENG_RESYNC:
            if (SUSPEND)
               next_eng = ENG_SUSP;
            else if (rsync == 4'h0)
               next_eng = ENG_RUN; // [R14]
            else
               next_rsync = rsync - 4'h1;
      endcase
      if (hw_set[`USIF_BIT_IDLE])
         next_act = ACT_ARMED; // [R16]
      else if (hw_set[`USIF_BIT_ACT])
         next_act = ACT_SPENT;
      next_clk_en = (next_eng != ENG_SUSP); // [R4]
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         eng <= ENG_RUN;
         act <= ACT_ARMED;
         rsync <= 4'h0;
         ENGINE_CLK_EN <= 1'b1;
      end
      else
      begin
         eng <= next_eng;
         act <= next_act;
         rsync <= next_rsync;
         ENGINE_CLK_EN <= next_clk_en;
      end
   end

   // checks
   property p_irq_set;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      (|(flags & enable)) |=> USB_IRQ;
   endproperty
   a_irq_set: assert property (p_irq_set) // [R1] [R18]
      else $error("enabled flag did not raise the request");
   property p_irq_masked;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      !(|(flags & enable)) |=> !USB_IRQ;
   endproperty
   a_irq_masked: assert property (p_irq_masked) // [R19]
      else $error("request raised with no enabled flag");
   property p_sticky;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      (flags[`USIF_BIT_SOF] && !wr_flags) |=> flags[`USIF_BIT_SOF];
   endproperty
   a_sticky: assert property (p_sticky) // [R2]
      else $error("frame start flag dropped without a write");
   property p_set_wins;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      (hw_set[`USIF_BIT_STALL] && wr_flags && !HWDATA[`USIF_BIT_STALL])
         |=> flags[`USIF_BIT_STALL];
   endproperty
   a_set_wins: assert property (p_set_wins) // [R21]
      else $error("clear beat a simultaneous set");
   property p_sw_set;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      (wr_flags && HWDATA[`USIF_BIT_TRN]) |=> flags[`USIF_BIT_TRN];
   endproperty
   a_sw_set: assert property (p_sw_set) // [R3]
      else $error("firmware write of one did not set the flag");
   property p_susp_quiet;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      (eng == ENG_SUSP && !flags[`USIF_BIT_RST] && !wr_flags)
         |=> !flags[`USIF_BIT_RST];
   endproperty
   a_susp_quiet: assert property (p_susp_quiet) // [R4]
      else $error("reset flag set while suspended");
   property p_bus_reset;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      (BUS_RESET && run) |=> (flags[`USIF_BIT_RST] && FUNC_ADDR == 7'h00);
   endproperty
   a_bus_reset: assert property (p_bus_reset) // [R13]
      else $error("bus reset did not flag or clear the address");
   property p_act_hold;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      (flags[`USIF_BIT_ACT] && eng != ENG_RUN) |=> flags[`USIF_BIT_ACT];
   endproperty
   a_act_hold: assert property (p_act_hold) // [R14]
      else $error("activity flag cleared while not resynchronised");
   property p_act_once;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      (act == ACT_SPENT && !flags[`USIF_BIT_ACT] && !wr_flags)
         |=> !flags[`USIF_BIT_ACT];
   endproperty
   a_act_once: assert property (p_act_once) // [R16]
      else $error("activity flagged twice without an idle");
   property p_err_ro;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      (|(ERR_FLAGS & ERR_ENABLES)) |=> flags[`USIF_BIT_ERR];
   endproperty
   a_err_ro: assert property (p_err_ro) // [R12] [R20]
      else $error("enabled error did not show in the summary");
   property p_advance;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      STAT_FIFO_ADVANCE |-> ($past(flags[`USIF_BIT_TRN]) && !flags[`USIF_BIT_TRN]);
   endproperty
   a_advance: assert property (p_advance) // [R10]
      else $error("fifo advanced without clearing the done flag");
   property p_top_zero;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      (HREADYOUT && $past(pend)) |-> HRDATA[`USIF_BIT_UNUSED] == 1'b0 || $past(ofs) != 8'h00;
   endproperty
   a_top_zero: assert property (p_top_zero) // [R5]
      else $error("unimplemented flag bit read as one");
endmodule
`default_nettype wire

// *** bench/usif_engine_model.sv ***
// behavioural serial engine: event pulses, line idle and pll lock
`timescale 1ns/10ps
`default_nettype none
module usif_engine_model
#(
   parameter int LOCK_DLY = 3
)
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // requests from the bench
   input wire logic [4:0] req,
   input wire logic idle_req,
   input wire logic suspend,
   // engine outputs
   output logic sof_rx,
   output logic stall_tx,
   output logic trn_done,
   output logic bus_reset,
   output logic bus_activity,
   output logic line_idle,
   output logic pll_locked
);
   int lock_cnt;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         {bus_activity, bus_reset, trn_done, stall_tx, sof_rx} <= 5'h00;
         line_idle <= 1'b0;
         lock_cnt <= LOCK_DLY;
         pll_locked <= 1'b1;
      end
      else
      begin
         // one-cycle event pulses
         {bus_activity, bus_reset, trn_done, stall_tx, sof_rx} <= req;
         line_idle <= idle_req;
         // pll lost in suspend, relocks some cycles after wake
         lock_cnt <= suspend ? 0 : (lock_cnt < LOCK_DLY ? lock_cnt + 1 : lock_cnt);
         pll_locked <= !suspend && (lock_cnt >= LOCK_DLY);
      end
   end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench of the status interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "usif_regs.svh"
module tb_top;
   typedef struct packed {logic [2:0] ev; logic [7:0] en; logic [7:0] flags; logic irq;}
      usif_row_t;
   logic SYS_CLK = 1'b0;
   logic ARST_N = 1'b0;
   logic HSEL = 1'b0;
   logic [31:0] HADDR = 32'h0;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [2:0] HSIZE = 3'h2;
   logic [31:0] HWDATA = 32'h0;
   logic [31:0] HRDATA;
   logic HREADYOUT, HRESP, USB_IRQ, ENGINE_CLK_EN, SUSPEND, STAT_FIFO_ADVANCE;
   logic [6:0] FUNC_ADDR;
   logic SOF_RX, STALL_TX, TRN_DONE, BUS_RESET, BUS_ACTIVITY, LINE_IDLE, PLL_LOCKED;
   logic [7:0] ERR_FLAGS = 8'h00;
   logic [7:0] ERR_ENABLES = 8'h00;
   logic [4:0] req = 5'h00;
   logic idle_req = 1'b0;
   logic [31:0] rd;
   int miscompares = 0;
   int checks = 0;
   int advances = 0;
   usif_row_t rows [5] = '{'{3'h0, 8'h40, 8'h40, 1'b1}, '{3'h1, 8'h00, 8'h20, 1'b0},
      '{3'h2, 8'h08, 8'h08, 1'b1}, '{3'h3, 8'h02, 8'h01, 1'b0}, '{3'h4, 8'h04, 8'h04, 1'b1}};
   usif_top #(.IDLE_CYCLES(20)) dut_u (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
      .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
      .SOF_RX(SOF_RX), .STALL_TX(STALL_TX), .TRN_DONE(TRN_DONE), .BUS_RESET(BUS_RESET),
      .BUS_ACTIVITY(BUS_ACTIVITY), .LINE_IDLE(LINE_IDLE), .PLL_LOCKED(PLL_LOCKED),
      .ERR_FLAGS(ERR_FLAGS), .ERR_ENABLES(ERR_ENABLES), .USB_IRQ(USB_IRQ),
      .ENGINE_CLK_EN(ENGINE_CLK_EN), .SUSPEND(SUSPEND), .FUNC_ADDR(FUNC_ADDR),
      .STAT_FIFO_ADVANCE(STAT_FIFO_ADVANCE));
   usif_engine_model eng_u (.clk(SYS_CLK), .arst_n(ARST_N), .req(req), .idle_req(idle_req),
      .suspend(SUSPEND), .sof_rx(SOF_RX), .stall_tx(STALL_TX), .trn_done(TRN_DONE),
      .bus_reset(BUS_RESET), .bus_activity(BUS_ACTIVITY), .line_idle(LINE_IDLE),
      .pll_locked(PLL_LOCKED));
   initial
   begin
      forever #5 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK)
   begin
      if (STAT_FIFO_ADVANCE === 1'b1)
         advances++;
   end
   task automatic finish_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, a};
      HWRITE <= wr;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic irqchk(input logic exp);
      repeat (2) @(posedge SYS_CLK);
      check({31'h0, USB_IRQ}, {31'h0, exp});
   endtask
   task automatic fire(input int i);
      req <= 5'h01 << i;
      @(posedge SYS_CLK);
      req <= 5'h00;
      repeat (3) @(posedge SYS_CLK);
   endtask
   task automatic idle(input int n);
      idle_req <= 1'b1;
      repeat (n) @(posedge SYS_CLK);
      idle_req <= 1'b0;
      repeat (3) @(posedge SYS_CLK);
   endtask
   initial
   begin
      #200000;
      miscompares++;
      finish_test();
   end
   initial
   begin
      repeat (6) @(posedge SYS_CLK);
      ARST_N <= 1'b1;
      @(posedge SYS_CLK);
      rchk(`USIF_OFS_FLAGS, 32'h0);
      rchk(`USIF_OFS_ENABLE, 32'h0);
      rchk(`USIF_OFS_CTRL, 32'h0);
      rchk(`USIF_OFS_FADDR, 32'h0);
      wr(8'h20, 32'hFFFFFFFF);
      rchk(8'h20, 32'h0);
      check({31'h0, HRESP}, 32'h0);
      // one event per row, enable decides the request line
      foreach (rows[k])
      begin
         wr(`USIF_OFS_ENABLE, {24'h0, rows[k].en});
         fire(rows[k].ev);
         check({31'h0, USB_IRQ}, {31'h0, rows[k].irq});
         rchk(`USIF_OFS_FLAGS, {24'h0, rows[k].flags});
         repeat (4) @(posedge SYS_CLK);
         rchk(`USIF_OFS_FLAGS, {24'h0, rows[k].flags});
         wr(`USIF_OFS_FLAGS, 32'h0);
         rchk(`USIF_OFS_FLAGS, 32'h0);
      end
      check(advances, 32'h1);
      wr(`USIF_OFS_ENABLE, 32'h0);
      wr(`USIF_OFS_FLAGS, 32'hFF);
      rchk(`USIF_OFS_FLAGS, 32'h7D);
      irqchk(1'b0);
      wr(`USIF_OFS_ENABLE, 32'h7F);
      irqchk(1'b1);
      wr(`USIF_OFS_FLAGS, 32'h0);
      irqchk(1'b0);
      ERR_FLAGS <= 8'h10;
      repeat (3) @(posedge SYS_CLK);
      rchk(`USIF_OFS_FLAGS, 32'h0);
      ERR_ENABLES <= 8'h10;
      repeat (3) @(posedge SYS_CLK);
      rchk(`USIF_OFS_FLAGS, 32'h02);
      wr(`USIF_OFS_FLAGS, 32'h0);
      rchk(`USIF_OFS_FLAGS, 32'h02);
      ERR_FLAGS <= 8'h00;
      repeat (3) @(posedge SYS_CLK);
      rchk(`USIF_OFS_FLAGS, 32'h0);
      wr(`USIF_OFS_FADDR, 32'h2A);
      check({25'h0, FUNC_ADDR}, 32'h2A);
      fire(3);
      check({25'h0, FUNC_ADDR}, 32'h0);
      wr(`USIF_OFS_FLAGS, 32'h0);
      // activity stays spent until a new idle flag
      fire(4);
      rchk(`USIF_OFS_FLAGS, 32'h0);
      idle(10);
      rchk(`USIF_OFS_FLAGS, 32'h0);
      idle(25);
      rchk(`USIF_OFS_FLAGS, 32'h10);
      fire(4);
      rchk(`USIF_OFS_FLAGS, 32'h14);
      wr(`USIF_OFS_FLAGS, 32'h0);
      idle(25);
      wr(`USIF_OFS_FLAGS, 32'h0);
      wr(`USIF_OFS_CTRL, 32'h2);
      check({31'h0, SUSPEND}, 32'h1);
      repeat (3) @(posedge SYS_CLK);
      check({31'h0, ENGINE_CLK_EN}, 32'h0);
      fire(0);
      fire(4);
      rchk(`USIF_OFS_FLAGS, 32'h04);
      rchk(`USIF_OFS_STATE, 32'h50);
      wr(`USIF_OFS_FLAGS, 32'h0);
      rchk(`USIF_OFS_FLAGS, 32'h04);
      // clear suspend first, then clear activity until it reads zero
      wr(`USIF_OFS_CTRL, 32'h0);
      for (int t = 0; t < 20; t++)
      begin
         ahb(1'b0, `USIF_OFS_FLAGS, 32'h0);
         if (rd[2] !== 1'b1)
            break;
         wr(`USIF_OFS_FLAGS, 32'h0);
      end
      check(rd, 32'h0);
      check({31'h0, ENGINE_CLK_EN}, 32'h1);
      fire(0);
      rchk(`USIF_OFS_FLAGS, 32'h40);
      // reset in mid-run
      ARST_N <= 1'b0;
      @(posedge SYS_CLK);
      check({31'h0, USB_IRQ}, 32'h0);
      ARST_N <= 1'b1;
      @(posedge SYS_CLK);
      rchk(`USIF_OFS_FLAGS, 32'h0);
      rchk(`USIF_OFS_ENABLE, 32'h0);
      rchk(`USIF_OFS_STATE, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
